// ---- status_regs.svh ----
// Bit positions, masks, widths and reset values of the status-reporting block
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// ======================================================================
// Widths
`define ESR_W 8
`define QUES_W 16
`define CODE_W 16
`define ERRQ_DEPTH 20
`define ERRQ_PTR_W 5
`define ERRQ_LAST 5'h13
`define ERRQ_PTR_ONE 5'h01
`define ERRQ_FULL 5'h14

// ======================================================================
// Standard event flag positions
`define ESR_OPC 0
`define ESR_QYE 2
`define ESR_DDE 3
`define ESR_EXE 4
`define ESR_CME 5
`define ESR_PON 7
`define ESR_USED_MASK 8'hbd

// ======================================================================
// Measurement quality flag positions
`define QUES_VOLT 0
`define QUES_CURR 1
`define QUES_OHMS 9
`define QUES_LIM_LO 11
`define QUES_LIM_HI 12
`define QUES_USED_MASK 16'h1a03

// ======================================================================
// Status byte summary positions
`define STB_QUES 3
`define STB_ESB 5

// ======================================================================
// Reset and fill values
`define ESR_RESET 8'h00
`define QUES_RESET 16'h0000
`define CODE_NONE 16'h0000
`define PTR_RESET 5'h00

`endif

// ---- status_pkg.sv ----
// Types shared by the status-reporting modules
package status_pkg;

   // ===================================================================
   // Commands from the remote command parser
   typedef enum logic [3:0] {
      cmd_esr_query,
      cmd_ese_write,
      cmd_ese_query,
      cmd_ques_event_query,
      cmd_ques_enable_write,
      cmd_ques_enable_query,
      cmd_status_preset,
      cmd_clear_status,
      cmd_psc_write,
      cmd_psc_query,
      cmd_error_query,
      cmd_stb_query
   } cmd_e;

   // ===================================================================
   // Function class of a reading overload
   typedef enum logic [1:0] {
      ovl_voltage,
      ovl_current,
      ovl_ohms
   } ovl_e;

   typedef logic [15:0] code_t;

endpackage : status_pkg

// ---- errq_if.sv ----
// Link between the status logic and its error queue
`timescale 1ns/1ps
interface errq_if;
   logic push;
   status_pkg::code_t push_code;
   logic pop;
   status_pkg::code_t head_code;
   logic empty;
   logic full;
   logic [4:0] count;

   modport producer (output push, output push_code, output pop,
                     input head_code, input empty, input full, input count);
   modport queue (input push, input push_code, input pop,
                  output head_code, output empty, output full, output count);
endinterface : errq_if

// ---- error_queue.sv ----
// First-in first-out store of error codes
`timescale 1ns/1ps
`include "status_regs.svh"
module error_queue (
   input wire logic clk, // Instrument clock
   input wire logic rstn, // Asynchronous reset, active low
   errq_if.queue q // Push and pop side
);

   status_pkg::code_t mem [`ERRQ_DEPTH];
   logic [`ERRQ_PTR_W-1:0] wr_q;
   logic [`ERRQ_PTR_W-1:0] rd_q;
   logic [`ERRQ_PTR_W-1:0] cnt_q;
   logic do_push;
   logic do_pop;

   function automatic logic [`ERRQ_PTR_W-1:0] wrap_inc(input logic [`ERRQ_PTR_W-1:0] p);
      wrap_inc = (p == `ERRQ_LAST) ? `PTR_RESET : p + `ERRQ_PTR_ONE;
   endfunction : wrap_inc

   // A push into a full queue is dropped: the oldest errors are kept
   assign do_push = q.push && (cnt_q != `ERRQ_FULL);
   assign do_pop = q.pop && (cnt_q != `PTR_RESET);
   assign q.empty = (cnt_q == `PTR_RESET);
   assign q.full = (cnt_q == `ERRQ_FULL);
   assign q.count = cnt_q;
   assign q.head_code = q.empty ? `CODE_NONE : mem[rd_q];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_q] <= q.push_code;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= `PTR_RESET;
         rd_q <= `PTR_RESET;
         cnt_q <= `PTR_RESET;
      end else begin
         if (do_push) begin
            wr_q <= wrap_inc(wr_q);
         end
         if (do_pop) begin
            rd_q <= wrap_inc(rd_q);
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + `ERRQ_PTR_ONE;
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - `ERRQ_PTR_ONE;
         end
      end
   end

endmodule : error_queue

// ---- scpi_event_status_registers.sv ----
// Standard event and measurement quality registers with masks and error queue
//
// How it works
// - Masked standard events OR into summary bit
// - Error bits two to five queue an error
// - Overload sets device error, quality bit, no queue
// - Operation complete sets bit zero
// - Three query fault causes set bit two
// - Self-test, calibration, overload set bit three
// - Failed execution sets bit four
// - Syntax error sets bit five
// - Power cycle sets bit seven until cleared
// - Standard event query clears the flags
// - Standard mask: zero write clears; power-on per setting
// - Overload class selects quality bit 0, 1, 9
// - Limit test sets bits eleven and twelve
// - Masked quality events OR into summary bit
// - Quality event query clears the flags
// - Quality mask cleared by zero write, power-on
// - Preset clears the quality mask
// - Clear status clears both event registers
// - Twenty-entry queue read oldest first
// - Queries return binary weighted register value
// - Summaries drive status byte bits three, five
// - Summaries unlatched, follow their event registers
`timescale 1ns/1ps
`include "status_regs.svh"
module scpi_event_status_registers (
   input wire logic clk, // Instrument clock, 50 MHz
   input wire logic rstn, // Power-on reset, active low
   input wire logic cmd_valid, // Command strobe, one cycle
   input wire status_pkg::cmd_e cmd_code, // Decoded command
   input wire logic [15:0] cmd_value, // Enable or setting value
   output logic resp_valid, // Query answer strobe
   output logic [15:0] resp_value, // Query answer, binary weighted
   input wire logic opc_done, // All commands through the completion mark done
   input wire logic qye_empty_read, // Read of an empty output buffer
   input wire logic qye_unread_query, // New line before a query answer was read
   input wire logic qye_buffers_full, // Input and output buffers both full
   input wire logic selftest_fail, // Self-test failure
   input wire logic cal_fail, // Calibration failure
   input wire logic exec_fail, // Command failed during execution
   input wire logic syntax_fail, // Command syntax error
   input wire logic [15:0] err_code, // Error number queued with a fault
   input wire logic overload, // Reading overload
   input wire status_pkg::ovl_e overload_kind, // Function class of the overload
   input wire logic limit_low, // Reading below lower limit
   input wire logic limit_high, // Reading above upper limit
   input wire logic psc_saved, // Stored power-on clear setting
   input wire logic [7:0] ese_saved, // Standard mask kept across power cycles
   output logic std_summary, // Standard event summary, status byte bit 5
   output logic ques_summary, // Quality summary, status byte bit 3
   output logic [7:0] ese_mask, // Standard mask, for retention outside
   output logic psc_value, // Current power-on clear setting
   output logic psc_write, // Pulse: store the new setting
   output logic [4:0] errq_count // Errors waiting in the queue
);

   // ===================================================================
   // Command decoding
   function automatic logic hit(input logic v, input status_pkg::cmd_e c,
                                input status_pkg::cmd_e want);
      hit = v && (c == want);
   endfunction : hit

   wire esr_query = hit(cmd_valid, cmd_code, status_pkg::cmd_esr_query);
   wire ese_write = hit(cmd_valid, cmd_code, status_pkg::cmd_ese_write);
   wire ese_query = hit(cmd_valid, cmd_code, status_pkg::cmd_ese_query);
   wire ques_query = hit(cmd_valid, cmd_code, status_pkg::cmd_ques_event_query);
   wire qen_write = hit(cmd_valid, cmd_code, status_pkg::cmd_ques_enable_write);
   wire qen_query = hit(cmd_valid, cmd_code, status_pkg::cmd_ques_enable_query);
   wire preset = hit(cmd_valid, cmd_code, status_pkg::cmd_status_preset);
   wire clear_status = hit(cmd_valid, cmd_code, status_pkg::cmd_clear_status);
   wire psc_cmd = hit(cmd_valid, cmd_code, status_pkg::cmd_psc_write);
   wire psc_query = hit(cmd_valid, cmd_code, status_pkg::cmd_psc_query);
   wire err_query = hit(cmd_valid, cmd_code, status_pkg::cmd_error_query);
   wire stb_query = hit(cmd_valid, cmd_code, status_pkg::cmd_stb_query);
   wire any_query = esr_query | ese_query | ques_query | qen_query | psc_query |
                    err_query | stb_query;

   // ===================================================================
   // State
   logic init_q;
   logic [7:0] esr_q;
   logic [7:0] esr_d;
   logic [7:0] ese_q;
   logic [7:0] ese_d;
   logic [15:0] ques_q;
   logic [15:0] ques_d;
   logic [15:0] qen_q;
   logic [15:0] qen_d;
   logic psc_q;
   logic psc_d;
   logic psc_wr_q;
   logic resp_valid_q;
   logic [15:0] resp_q;
   logic [15:0] resp_d;

   errq_if eq ();

   error_queue u_errq (
      .clk(clk),
      .rstn(rstn),
      .q(eq)
   );

   // ===================================================================
   // Standard event sources
   wire qye_set = qye_empty_read | qye_unread_query | qye_buffers_full;
   wire dve_fault = selftest_fail | cal_fail;
   wire dve_set = dve_fault | overload;
   wire pon_set = !init_q;

   wire [7:0] esr_set = ({7'h00, opc_done} << `ESR_OPC) |
                        ({7'h00, qye_set} << `ESR_QYE) |
                        ({7'h00, dve_set} << `ESR_DDE) |
                        ({7'h00, exec_fail} << `ESR_EXE) |
                        ({7'h00, syntax_fail} << `ESR_CME) |
                        ({7'h00, pon_set} << `ESR_PON);

   // A flag raised in the cycle of its clear survives: set wins
   wire esr_clear = esr_query | clear_status;
   assign esr_d = ((esr_clear ? `ESR_RESET : esr_q) | esr_set) & `ESR_USED_MASK;

   // ===================================================================
   // Error queue feed
   // Overload alone raises no push, so it never reaches the queue
   assign eq.push = qye_set | dve_fault | exec_fail | syntax_fail;
   assign eq.push_code = err_code;
   assign eq.pop = err_query;
   assign errq_count = eq.count;

   // ===================================================================
   // Measurement quality sources
   wire ovl_volt = overload && (overload_kind == status_pkg::ovl_voltage);
   wire ovl_curr = overload && (overload_kind == status_pkg::ovl_current);
   wire ovl_ohms = overload && (overload_kind == status_pkg::ovl_ohms);

   wire [15:0] ques_set = ({15'h0000, ovl_volt} << `QUES_VOLT) |
                          ({15'h0000, ovl_curr} << `QUES_CURR) |
                          ({15'h0000, ovl_ohms} << `QUES_OHMS) |
                          ({15'h0000, limit_low} << `QUES_LIM_LO) |
                          ({15'h0000, limit_high} << `QUES_LIM_HI);

   wire ques_clear = ques_query | clear_status;
   assign ques_d = ((ques_clear ? `QUES_RESET : ques_q) | ques_set) &
                   `QUES_USED_MASK;

   // ===================================================================
   // Enable masks and power-on clear setting
   // The retained mask is taken one edge after release; async reset loads constants only
   // Stored setting read directly: psc_q itself is only loaded on this same edge
   wire [7:0] ese_power = psc_saved ? `ESR_RESET : ese_saved;
   assign ese_d = !init_q ? ese_power :
                  ese_write ? cmd_value[7:0] :
                  ese_q;
   assign qen_d = (preset ? `QUES_RESET :
                   qen_write ? cmd_value :
                   qen_q);
   assign psc_d = !init_q ? psc_saved :
                  psc_cmd ? cmd_value[0] :
                  psc_q;

   // ===================================================================
   // Summaries: combinational so a cleared register drops its bit at once
   assign std_summary = |(esr_q & ese_q);
   assign ques_summary = |(ques_q & qen_q);
   wire [15:0] stb_bits = ({15'h0000, ques_summary} << `STB_QUES) |
                          ({15'h0000, std_summary} << `STB_ESB);

   // ===================================================================
   // Query answers, always the raw binary weight of the bits
   assign resp_d = esr_query ? {8'h00, esr_q} :
                   ese_query ? {8'h00, ese_q} :
                   ques_query ? ques_q :
                   qen_query ? qen_q :
                   psc_query ? {15'h0000, psc_q} :
                   err_query ? eq.head_code :
                   stb_query ? stb_bits :
                   resp_q;

   // ===================================================================
   // Registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         init_q <= 1'b0;
         psc_q <= 1'b0;
         psc_wr_q <= 1'b0;
      end else begin
         init_q <= 1'b1;
         psc_q <= psc_d;
         psc_wr_q <= psc_cmd;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         esr_q <= `ESR_RESET;
         ques_q <= `QUES_RESET;
      end else begin
         esr_q <= esr_d;
         ques_q <= ques_d;
      end
   end

   // Quality mask clears on every power-on regardless of the setting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ese_q <= `ESR_RESET;
         qen_q <= `QUES_RESET;
      end else begin
         ese_q <= ese_d;
         qen_q <= qen_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         resp_valid_q <= 1'b0;
         resp_q <= `QUES_RESET;
      end else begin
         resp_valid_q <= any_query;
         resp_q <= resp_d;
      end
   end

   // ===================================================================
   // Outputs
   assign resp_valid = resp_valid_q;
   assign resp_value = resp_q;
   assign ese_mask = ese_q;
   assign psc_value = psc_q;
   assign psc_write = psc_wr_q;

endmodule : scpi_event_status_registers

// ---- scpi_event_status_registers_props.sv ----
// Port-level checker for the status-reporting block
`timescale 1ns/1ps
`include "status_regs.svh"
module scpi_event_status_registers_props (
   input wire logic clk, // Instrument clock
   input wire logic rstn, // Reset, active low
   input wire logic cmd_valid, // Command strobe
   input wire status_pkg::cmd_e cmd_code, // Decoded command
   input wire logic [15:0] cmd_value, // Command value
   input wire logic resp_valid, // Answer strobe
   input wire logic [15:0] resp_value, // Answer value
   input wire logic opc_done, // Completion event
   input wire logic qye_empty_read, // Query fault
   input wire logic qye_unread_query, // Query fault
   input wire logic qye_buffers_full, // Query fault
   input wire logic selftest_fail, // Device fault
   input wire logic cal_fail, // Device fault
   input wire logic exec_fail, // Execution fault
   input wire logic syntax_fail, // Syntax fault
   input wire logic overload, // Reading overload
   input wire logic std_summary, // Standard summary
   input wire logic ques_summary, // Quality summary
   input wire logic [7:0] ese_mask, // Standard mask
   input wire logic [4:0] errq_count // Queue fill
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ===================================================================
   // Decodes
   wire any_err = qye_empty_read | qye_unread_query | qye_buffers_full | selftest_fail
      | cal_fail | exec_fail | syntax_fail;
   wire is_query = cmd_valid && !(cmd_code inside {status_pkg::cmd_ese_write,
      status_pkg::cmd_ques_enable_write, status_pkg::cmd_status_preset,
      status_pkg::cmd_clear_status, status_pkg::cmd_psc_write});

   // ===================================================================
   // Properties
   AST_QUERY_ANSWER: assert property (is_query |=> resp_valid)
      else $error("query not answered next cycle");
   AST_NO_ANSWER: assert property (cmd_valid && !is_query |=> !resp_valid)
      else $error("write command produced an answer");
   AST_ESE_WRITE: assert property (cmd_valid && cmd_code == status_pkg::cmd_ese_write
      |=> ese_mask == $past(cmd_value[7:0])) else $error("standard mask not written");
   AST_OPC_SUMMARY: assert property (opc_done && ese_mask[`ESR_OPC] && !cmd_valid
      |=> std_summary) else $error("completion did not reach summary");
   AST_CME_SUMMARY: assert property (syntax_fail && ese_mask[`ESR_CME] && !cmd_valid
      |=> std_summary) else $error("syntax fault did not reach summary");
   AST_ERR_PUSH: assert property (any_err && !cmd_valid && errq_count != `ERRQ_FULL
      |=> errq_count == $past(errq_count) + 5'h01) else $error("fault not queued");
   AST_OVL_NOPUSH: assert property (overload && !any_err && !cmd_valid
      |=> $stable(errq_count)) else $error("overload queued an entry");
   AST_QUEUE_BOUND: assert property (errq_count <= `ERRQ_FULL)
      else $error("queue fill above depth");
   AST_STB_ANSWER: assert property (cmd_valid && cmd_code == status_pkg::cmd_stb_query
      |=> resp_value == {10'h000, $past(std_summary), 1'b0, $past(ques_summary), 3'h0})
      else $error("status byte answer wrong");
   AST_ESR_CLEAR: assert property (cmd_valid && cmd_code == status_pkg::cmd_esr_query
      && !opc_done && !any_err && !overload |=> !std_summary)
      else $error("summary stayed after flag read");

   COV_FULL: cover property (errq_count == 5'(`ERRQ_DEPTH));
   COV_OVL: cover property (overload ##1 ques_summary);
   COV_CLR: cover property (cmd_valid && cmd_code == status_pkg::cmd_clear_status && std_summary);
endmodule : scpi_event_status_registers_props

bind scpi_event_status_registers scpi_event_status_registers_props u_props (.clk, .rstn,
   .cmd_valid, .cmd_code, .cmd_value, .resp_valid, .resp_value, .opc_done, .qye_empty_read,
   .qye_unread_query, .qye_buffers_full, .selftest_fail, .cal_fail, .exec_fail,
   .syntax_fail, .overload, .std_summary, .ques_summary, .ese_mask, .errq_count);

// ---- host_model.sv ----
// Remote controller model issuing commands and reading answers
`timescale 1ns/1ps
module host_model (
   input wire logic clk, // Instrument clock
   output logic cmd_valid, // Command strobe
   output status_pkg::cmd_e cmd_code, // Command selector
   output logic [15:0] cmd_value, // Command value
   input wire logic resp_valid, // Answer strobe
   input wire logic [15:0] resp_value // Answer value
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = status_pkg::cmd_stb_query;
      cmd_value = 16'h0000;
   end

   // ===================================================================
   // One command, one cycle; value scrambled once released
   task automatic send(input status_pkg::cmd_e c, input logic [15:0] v);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_value <= v;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_value <= ~v;
   endtask : send

   task automatic ask(input status_pkg::cmd_e c, output logic [16:0] r);
      send(c, 16'h0000);
      #1;
      r = {resp_valid, resp_value};
   endtask : ask
endmodule : host_model

// ---- scpi_event_status_registers_tb.sv ----
// Self-checking bench for the status-reporting block
`timescale 1ns/1ps
module scpi_event_status_registers_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [10:0] ev = 11'h000;
   logic [15:0] err_code = 16'h0000;
   status_pkg::ovl_e overload_kind = status_pkg::ovl_voltage;
   logic psc_saved = 1'b0;
   logic [7:0] ese_saved = 8'ha5;
   logic cmd_valid;
   status_pkg::cmd_e cmd_code;
   logic [15:0] cmd_value;
   logic resp_valid;
   logic [15:0] resp_value;
   logic std_summary;
   logic ques_summary;
   logic [7:0] ese_mask;
   logic [4:0] errq_count;
   logic psc_value;
   logic psc_write;
   logic [16:0] r;
   int bad_count = 0;
   int checks_done = 0;

   always #10 clk = ~clk;

   scpi_event_status_registers u_scpi_event_status_registers (.clk(clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_value(cmd_value),
      .resp_valid(resp_valid), .resp_value(resp_value), .opc_done(ev[0]),
      .qye_empty_read(ev[1]), .qye_unread_query(ev[2]), .qye_buffers_full(ev[3]),
      .selftest_fail(ev[4]), .cal_fail(ev[5]), .exec_fail(ev[6]), .syntax_fail(ev[7]),
      .err_code(err_code), .overload(ev[8]), .overload_kind(overload_kind),
      .limit_low(ev[9]), .limit_high(ev[10]), .psc_saved(psc_saved), .ese_saved(ese_saved),
      .std_summary(std_summary), .ques_summary(ques_summary), .ese_mask(ese_mask),
      .psc_value(psc_value), .psc_write(psc_write), .errq_count(errq_count));

   host_model u_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_value(cmd_value), .resp_valid(resp_valid), .resp_value(resp_value));

   // ===================================================================
   // Shared helpers
   task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic q(input status_pkg::cmd_e c, input logic [15:0] e);
      u_host_model.ask(c, r);
      chk(c.name(), {1'b1, e}, r);
   endtask : q

   // Event pulse of one cycle; flags are settled on return
   task automatic fire(input logic [10:0] m, input logic [15:0] code);
      @(posedge clk);
      ev <= m;
      err_code <= code;
      @(posedge clk);
      ev <= 11'h000;
      #1;
   endtask : fire

   task automatic do_reset(input logic p);
      @(posedge clk);
      psc_saved <= p;
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask : do_reset

   // ===================================================================
   // Scenarios
   task automatic t_power_on;
      chk("ese_mask", {9'h000, ese_saved}, {9'h000, ese_mask});
      chk("psc_value", 17'h00000, {16'h0000, psc_value});
      q(status_pkg::cmd_esr_query, 16'h0080);
      q(status_pkg::cmd_esr_query, 16'h0000);
      q(status_pkg::cmd_ques_enable_query, 16'h0000);
   endtask : t_power_on

   task automatic t_events;
      logic [15:0] w [8] = '{16'h0001, 16'h0004, 16'h0004, 16'h0004,
         16'h0008, 16'h0008, 16'h0010, 16'h0020};
      for (int i = 0; i < 8; i++) begin
         fire(11'h001 << i, 16'h0100 + 16'(i));
         chk("errq_count", 17'(i), {12'h000, errq_count});
         q(status_pkg::cmd_esr_query, w[i]);
      end
      fire(11'h0ff, 16'h01ff);
      q(status_pkg::cmd_esr_query, 16'h003d);
      for (int i = 1; i < 9; i++) begin
         q(status_pkg::cmd_error_query, (i < 8) ? 16'h0100 + 16'(i) : 16'h01ff);
      end
      q(status_pkg::cmd_error_query, 16'h0000);
   endtask : t_events

   task automatic t_overload;
      logic [15:0] qw [3] = '{16'h0001, 16'h0002, 16'h0200};
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         overload_kind <= status_pkg::ovl_e'(k);
         fire(11'h100, 16'h0300);
         chk("errq_count", 17'h00000, {12'h000, errq_count});
         q(status_pkg::cmd_esr_query, 16'h0008);
         q(status_pkg::cmd_ques_event_query, qw[k]);
      end
      fire(11'h600, 16'h0000);
      q(status_pkg::cmd_ques_event_query, 16'h1800);
      q(status_pkg::cmd_ques_event_query, 16'h0000);
   endtask : t_overload

   task automatic t_masks;
      u_host_model.send(status_pkg::cmd_ese_write, 16'h0020);
      fire(11'h080, 16'h0300);
      chk("std_summary", 17'h00001, {16'h0000, std_summary});
      q(status_pkg::cmd_stb_query, 16'h0020);
      q(status_pkg::cmd_ese_query, 16'h0020);
      q(status_pkg::cmd_esr_query, 16'h0020);
      chk("std_summary", 17'h00000, {16'h0000, std_summary});
      u_host_model.send(status_pkg::cmd_ques_enable_write, 16'h1200);
      fire(11'h580, 16'h0300);
      q(status_pkg::cmd_stb_query, 16'h0028);
      u_host_model.send(status_pkg::cmd_clear_status, 16'h0000);
      #1;
      chk("summaries", 17'h00000, {15'h0000, std_summary, ques_summary});
      q(status_pkg::cmd_ques_event_query, 16'h0000);
      q(status_pkg::cmd_ques_enable_query, 16'h1200);
      u_host_model.send(status_pkg::cmd_status_preset, 16'h0000);
      q(status_pkg::cmd_ques_enable_query, 16'h0000);
      u_host_model.send(status_pkg::cmd_ese_write, 16'h0000);
      q(status_pkg::cmd_ese_query, 16'h0000);
   endtask : t_masks

   task automatic t_full;
      for (int i = 0; i < 22; i++) begin
         fire(11'h040, 16'h0200 + 16'(i));
      end
      chk("errq_count", 17'd20, {12'h000, errq_count});
      q(status_pkg::cmd_error_query, 16'h0300);
   endtask : t_full

   task automatic t_psc;
      u_host_model.send(status_pkg::cmd_psc_write, 16'h0001);
      #1;
      chk("psc_write", 17'h00001, {16'h0000, psc_write});
      u_host_model.send(status_pkg::cmd_ques_enable_write, 16'hffff);
      #1;
      chk("psc_write", 17'h00000, {16'h0000, psc_write});
      q(status_pkg::cmd_psc_query, 16'h0001);
      do_reset(1'b1);
      chk("ese_mask", 17'h00000, {9'h000, ese_mask});
      chk("psc_value", 17'h00001, {16'h0000, psc_value});
      q(status_pkg::cmd_ques_enable_query, 16'h0000);
      q(status_pkg::cmd_esr_query, 16'h0080);
   endtask : t_psc

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   initial begin
      do_reset(1'b0);
      t_power_on();
      t_events();
      t_overload();
      t_masks();
      t_full();
      t_psc();
      final_report();
   end
endmodule : scpi_event_status_registers_tb
